// ### logic/pha_defines.svh
// Offsets, field positions, reset values and timing counts of the alert block.
`ifndef PHA_DEFINES_SVH
`define PHA_DEFINES_SVH

`define PHA_CLK_PERIOD_NS 50
`define PHA_CYC_MIN(ns) (((ns) + `PHA_CLK_PERIOD_NS - 1) / `PHA_CLK_PERIOD_NS)

`define PHA_ADDR_THR_TIMING 8'h33
`define PHA_ADDR_SRC_EN     8'h34
`define PHA_RST_THR_TIMING  16'h4A54
`define PHA_RST_SRC_EN      16'h8120

`define PHA_F_L2_HI     15
`define PHA_F_L2_LO     11
`define PHA_F_CRIT_HI   10
`define PHA_F_CRIT_LO   9
`define PHA_F_VSYS_HI   7
`define PHA_F_VSYS_LO   6
`define PHA_F_EXT       5
`define PHA_F_WIDTH_HI  4
`define PHA_F_WIDTH_LO  3
`define PHA_F_CLEAR     2
`define PHA_F_NOMINAL_OVERCURRENT_DEBOUNCE  1
`define PHA_F_IDCHG_HI  15
`define PHA_F_IDCHG_LO  10
`define PHA_F_DDEG_HI   9
`define PHA_F_DDEG_LO   8
`define PHA_F_SRC_HI    6
`define PHA_F_EN_COMP   6
`define PHA_F_EN_CRIT   5
`define PHA_F_EN_NOMINAL_INPUT_OVERCURRENT   4
`define PHA_F_EN_IDCHG  3
`define PHA_F_EN_VSYS   2
`define PHA_F_EN_BATT   1
`define PHA_F_EN_ADAPT  0

`define PHA_T_CRIT_DEB0_NS   15000
`define PHA_T_CRIT_DEB1_NS   100000
`define PHA_T_CRIT_DEB2_NS   400000
`define PHA_T_CRIT_DEB3_NS   800000
`define PHA_T_VSYS_DEB_NS    20000
`define PHA_T_NOMINAL_INPUT_OVERCURRENT_DEB0_NS   1000000
`define PHA_T_NOMINAL_INPUT_OVERCURRENT_DEB1_NS   50000000
`define PHA_T_IDCHG_DEB0_NS  1600000
`define PHA_T_IDCHG_DEB1_NS  100000
`define PHA_T_IDCHG_DEB2_NS  6000000
`define PHA_T_IDCHG_DEB3_NS  12000000
`define PHA_T_WIDTH0_NS      100000
`define PHA_T_WIDTH1_NS      1000000
`define PHA_T_WIDTH2_NS      10000000
`define PHA_T_WIDTH3_NS      5000000

`define PHA_L2_BASE_PCT     105
`define PHA_L2_STEP_PCT     5
`define PHA_L2_FINE_LAST    25
`define PHA_L2_COARSE_BASE  250
`define PHA_L2_COARSE_STEP  50
`define PHA_L2_COARSE_FIRST 26
`define PHA_L2_IGNORED      31
`define PHA_CRIT_OF_L2_X10  11
`define PHA_NOMINAL_INPUT_OVERCURRENT_X10        11
`define PHA_IDCHG_STEP_SH   9
`define PHA_IDCHG_OFS_MA    128
`define PHA_VSYS_MULTI_MV   5750
`define PHA_VSYS_SINGLE_MV  2850
`define PHA_VSYS_STEP_MV    250

`endif

// ### logic/pha_pkg.sv
// Types shared by the processor-hot alert modules.
package pha_pkg;

  typedef logic [23:0] pha_cnt_t;

  typedef enum logic [2:0] {
    PHA_IDLE   = 3'b001,
    PHA_HOLD   = 3'b010,
    PHA_EXTEND = 3'b100
  } pha_fsm_t;

  typedef struct packed {
    pha_cnt_t cnt;
    logic     trip;
  } pha_deb_state_t;

  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] rdata;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        batt_prev;
    pha_fsm_t    fsm;
    pha_cnt_t    width_cnt;
    logic        alert_n;
  } pha_state_t;

endpackage

// ### logic/pha_deb_if.sv
// Condition, hold time and trip flag between the alert logic and a debouncer.
`timescale 1ns/1ps
interface pha_deb_if;
  import pha_pkg::*;
  logic     cond;
  pha_cnt_t limit;
  logic     trip;
  modport src (output cond, output limit, input trip);
  modport deb (input cond, input limit, output trip);
endinterface

// ### logic/pha_debounce.sv
// Debouncer: trips once its condition has held for the given number of cycles.
`timescale 1ns/1ps
module pha_debounce
  import pha_pkg::*;
(
  // Clock and reset.
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Condition and result.
  pha_deb_if.deb    deb
);

  pha_deb_state_t s_q;
  pha_deb_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!deb.cond) begin
      s_d.cnt  = '0;
      s_d.trip = 1'b0;
    end else if (s_q.cnt + 24'h000001 >= deb.limit) begin
      s_d.trip = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign deb.trip = s_q.trip;

endmodule

// ### logic/pha_alert_gen.sv
// Processor-hot alert generator: thresholds, debounce, source enables, pin.
`timescale 1ns/1ps
`include "pha_defines.svh"
module pha_alert_gen
  import pha_pkg::*;
#(
  parameter int unsigned CRIT_DEB_CYC [4] = '{
    `PHA_CYC_MIN(`PHA_T_CRIT_DEB0_NS), `PHA_CYC_MIN(`PHA_T_CRIT_DEB1_NS),
    `PHA_CYC_MIN(`PHA_T_CRIT_DEB2_NS), `PHA_CYC_MIN(`PHA_T_CRIT_DEB3_NS)},
  parameter int unsigned VSYS_DEB_CYC = `PHA_CYC_MIN(`PHA_T_VSYS_DEB_NS),
  parameter int unsigned NOMINAL_INPUT_OVERCURRENT_DEB_CYC [2] = '{
    `PHA_CYC_MIN(`PHA_T_NOMINAL_INPUT_OVERCURRENT_DEB0_NS), `PHA_CYC_MIN(`PHA_T_NOMINAL_INPUT_OVERCURRENT_DEB1_NS)},
  parameter int unsigned IDCHG_DEB_CYC [4] = '{
    `PHA_CYC_MIN(`PHA_T_IDCHG_DEB0_NS), `PHA_CYC_MIN(`PHA_T_IDCHG_DEB1_NS),
    `PHA_CYC_MIN(`PHA_T_IDCHG_DEB2_NS), `PHA_CYC_MIN(`PHA_T_IDCHG_DEB3_NS)},
  parameter int unsigned WIDTH_CYC [4] = '{
    `PHA_CYC_MIN(`PHA_T_WIDTH0_NS), `PHA_CYC_MIN(`PHA_T_WIDTH1_NS),
    `PHA_CYC_MIN(`PHA_T_WIDTH2_NS), `PHA_CYC_MIN(`PHA_T_WIDTH3_NS)}
)
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register access from the host-side serial engine.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_en_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_en_i,
  output logic      [15:0] reg_rdata_o,
  // Digitised measurements and limit, same clock domain.
  input  wire logic [15:0] input_current_ma_i,
  input  wire logic [15:0] input_current_limit_ma_i,
  input  wire logic [15:0] discharge_current_ma_i,
  input  wire logic [15:0] system_voltage_mv_i,
  input  wire logic        single_cell_i,
  // Asynchronous status pins.
  input  wire logic        battery_present_i,
  input  wire logic        adapter_present_i,
  input  wire logic        comparator_trip_i,
  // Alert pin toward the host processor.
  output logic             processor_hot_alert_n_o
);

  localparam int unsigned NUM_DEB = 4;
  localparam int unsigned DEB_CRIT = 0;
  localparam int unsigned DEB_NOMINAL_INPUT_OVERCURRENT = 1;
  localparam int unsigned DEB_IDCHG = 2;
  localparam int unsigned DEB_VSYS = 3;
  localparam int unsigned PIN_BATT = 0;
  localparam int unsigned PIN_ADAPT = 1;
  localparam int unsigned PIN_COMP = 2;

  pha_state_t  s_q;
  pha_state_t  s_d;

  logic        cond    [NUM_DEB];
  pha_cnt_t    limit   [NUM_DEB];
  logic        tripped [NUM_DEB];

  logic [4:0]  l2_code;
  logic [8:0]  l2_pct;
  logic        l2_valid;
  logic [31:0] cur_x100;
  logic [31:0] cur_x1000;
  logic [31:0] lim_x_pct;
  logic [31:0] lim_x_pct_crit;
  logic        over_l2;
  logic        over_crit;
  logic        over_nominal_input_overcurrent;
  logic [16:0] idchg_thr;
  logic        over_idchg;
  logic [15:0] vsys_thr;
  logic        under_vsys;
  logic        func_en;
  logic        batt_fall;
  logic        trigger;
  logic        clear_wr;
  logic        ext_en;
  pha_cnt_t    width_lim;

  // Level-two percentage per code; zero marks a code that is ignored.
  function automatic logic [8:0] l2_pct_of(input logic [4:0] code);
    logic [8:0] pct;
    pct = 9'h000;
    if (code >= 5'h01 && code <= 5'(`PHA_L2_FINE_LAST)) begin
      pct = 9'(`PHA_L2_BASE_PCT + `PHA_L2_STEP_PCT * code);
    end else if (code >= 5'(`PHA_L2_COARSE_FIRST)
                 && code != 5'(`PHA_L2_IGNORED)) begin
      pct = 9'(`PHA_L2_COARSE_BASE
               + `PHA_L2_COARSE_STEP * (code - 5'(`PHA_L2_COARSE_FIRST)));
    end
    return pct;
  endfunction

  // Threshold comparisons.
  always_comb begin
    l2_code        = s_q.cfg0[`PHA_F_L2_HI:`PHA_F_L2_LO];
    l2_pct         = l2_pct_of(l2_code);
    l2_valid       = (l2_pct != 9'h000);
    cur_x100       = 32'(input_current_ma_i) * 32'd100;
    cur_x1000      = 32'(input_current_ma_i) * 32'd1000;
    lim_x_pct      = 32'(input_current_limit_ma_i) * 32'(l2_pct);
    lim_x_pct_crit = lim_x_pct * 32'(`PHA_CRIT_OF_L2_X10);
    over_l2        = l2_valid && (cur_x100 > lim_x_pct);
    over_crit      = over_l2 && (cur_x1000 > lim_x_pct_crit);
    over_nominal_input_overcurrent      = (32'(input_current_ma_i) * 32'd10)
                     > (32'(input_current_limit_ma_i)
                        * 32'(`PHA_NOMINAL_INPUT_OVERCURRENT_X10));
    idchg_thr      = (17'(s_q.cfg1[`PHA_F_IDCHG_HI:`PHA_F_IDCHG_LO])
                      << `PHA_IDCHG_STEP_SH)
                     + 17'(`PHA_IDCHG_OFS_MA);
    over_idchg     = 17'(discharge_current_ma_i) > idchg_thr;
    vsys_thr       = (single_cell_i ? 16'(`PHA_VSYS_SINGLE_MV)
                                    : 16'(`PHA_VSYS_MULTI_MV))
                     + 16'(16'(`PHA_VSYS_STEP_MV)
                           * 16'(s_q.cfg0[`PHA_F_VSYS_HI:`PHA_F_VSYS_LO]));
    under_vsys     = system_voltage_mv_i < vsys_thr;
  end

  // Debounce conditions and hold times.
  always_comb begin
    cond[DEB_CRIT]   = over_crit;
    cond[DEB_NOMINAL_INPUT_OVERCURRENT]   = over_nominal_input_overcurrent;
    cond[DEB_IDCHG]  = over_idchg;
    cond[DEB_VSYS]   = under_vsys;
    limit[DEB_CRIT]  = pha_cnt_t'(
      CRIT_DEB_CYC[s_q.cfg0[`PHA_F_CRIT_HI:`PHA_F_CRIT_LO]]);
    limit[DEB_NOMINAL_INPUT_OVERCURRENT]  = pha_cnt_t'(
      NOMINAL_INPUT_OVERCURRENT_DEB_CYC[s_q.cfg0[`PHA_F_NOMINAL_OVERCURRENT_DEBOUNCE]]);
    limit[DEB_IDCHG] = pha_cnt_t'(
      IDCHG_DEB_CYC[s_q.cfg1[`PHA_F_DDEG_HI:`PHA_F_DDEG_LO]]);
    limit[DEB_VSYS]  = pha_cnt_t'(VSYS_DEB_CYC);
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DEB; gi++) begin : g_deb
      pha_deb_if deb_bus ();
      assign deb_bus.cond  = cond[gi];
      assign deb_bus.limit = limit[gi];
      assign tripped[gi]   = deb_bus.trip;
      pha_debounce u_deb (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .deb     (deb_bus.deb)
      );
    end
  endgenerate

  // Source combination.
  always_comb begin
    func_en   = |s_q.cfg1[`PHA_F_SRC_HI:0];
    batt_fall = s_q.batt_prev && !s_q.sync2[PIN_BATT];
    trigger   = func_en && (
        (s_q.cfg1[`PHA_F_EN_COMP]  && s_q.sync2[PIN_COMP])
      | (s_q.cfg1[`PHA_F_EN_CRIT]  && tripped[DEB_CRIT])
      | (s_q.cfg1[`PHA_F_EN_NOMINAL_INPUT_OVERCURRENT]  && tripped[DEB_NOMINAL_INPUT_OVERCURRENT])
      | (s_q.cfg1[`PHA_F_EN_IDCHG] && tripped[DEB_IDCHG])
      | (s_q.cfg1[`PHA_F_EN_VSYS]  && tripped[DEB_VSYS])
      | (s_q.cfg1[`PHA_F_EN_BATT]  && batt_fall)
      | (s_q.cfg1[`PHA_F_EN_ADAPT] && !s_q.sync2[PIN_ADAPT]));
    clear_wr  = reg_wr_en_i && (reg_addr_i == `PHA_ADDR_THR_TIMING)
                && !reg_wdata_i[`PHA_F_CLEAR];
    ext_en    = s_q.cfg0[`PHA_F_EXT];
    width_lim = pha_cnt_t'(
      WIDTH_CYC[s_q.cfg0[`PHA_F_WIDTH_HI:`PHA_F_WIDTH_LO]]);
  end

  // Next state: registers, synchronisers and the alert sequencer.
  always_comb begin
    s_d = s_q;

    s_d.sync1     = {comparator_trip_i, adapter_present_i, battery_present_i};
    s_d.sync2     = s_q.sync1;
    s_d.batt_prev = s_q.sync2[PIN_BATT];

    // The clear bit reads back idle; a written zero acts once.
    if (reg_wr_en_i) begin
      if (reg_addr_i == `PHA_ADDR_THR_TIMING) begin
        s_d.cfg0 = reg_wdata_i;
        s_d.cfg0[`PHA_F_CLEAR] = 1'b1;
      end else if (reg_addr_i == `PHA_ADDR_SRC_EN) begin
        s_d.cfg1 = reg_wdata_i;
      end
    end

    if (reg_rd_en_i) begin
      if (reg_addr_i == `PHA_ADDR_THR_TIMING) begin
        s_d.rdata = s_q.cfg0;
      end else if (reg_addr_i == `PHA_ADDR_SRC_EN) begin
        s_d.rdata = s_q.cfg1;
      end else begin
        s_d.rdata = 16'h0000;
      end
    end

    case (s_q.fsm)
      PHA_IDLE: begin
        s_d.alert_n = 1'b1;
        if (trigger) begin
          s_d.width_cnt = 24'h000001;
          s_d.alert_n   = 1'b0;
          s_d.fsm       = ext_en ? PHA_EXTEND : PHA_HOLD;
        end
      end
      PHA_HOLD: begin
        if (!func_en) begin
          s_d.fsm     = PHA_IDLE;
          s_d.alert_n = 1'b1;
        end else if (ext_en) begin
          s_d.fsm = PHA_EXTEND;
        end else if (s_q.width_cnt < width_lim) begin
          s_d.width_cnt = s_q.width_cnt + 24'h000001;
        end else if (!trigger) begin
          s_d.fsm     = PHA_IDLE;
          s_d.alert_n = 1'b1;
        end
      end
      PHA_EXTEND: begin
        // A trigger in the cycle of the clear keeps the pin low.
        if (!func_en) begin
          s_d.fsm     = PHA_IDLE;
          s_d.alert_n = 1'b1;
        end else if (!ext_en) begin
          s_d.fsm       = PHA_HOLD;
          s_d.width_cnt = width_lim;
        end else if (clear_wr && !trigger) begin
          s_d.fsm     = PHA_IDLE;
          s_d.alert_n = 1'b1;
        end
      end
      default: begin
        s_d.fsm     = PHA_IDLE;
        s_d.alert_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q           <= '0;
      s_q.cfg0      <= `PHA_RST_THR_TIMING;
      s_q.cfg1      <= `PHA_RST_SRC_EN;
      // Synchronisers start at the idle pin levels, so no false edge follows.
      s_q.sync1     <= 3'b011;
      s_q.sync2     <= 3'b011;
      s_q.batt_prev <= 1'b1;
      s_q.fsm       <= PHA_IDLE;
      s_q.alert_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o             = s_q.rdata;
  assign processor_hot_alert_n_o = s_q.alert_n;

endmodule

// ### sim/pha_host_model.sv
// Host-side model that watches the alert pin and measures its pulses.
`timescale 1ns/1ps
module pha_host_model (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Alert pin and what the host saw on it.
  input  wire logic        alert_n_i,
  output logic      [15:0] low_cyc_o,
  output logic      [7:0]  pulses_o
);
  logic [15:0] run_q;

  // The host counts low cycles and logs each finished pulse.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q     <= 16'h0000;
      low_cyc_o <= 16'h0000;
      pulses_o  <= 8'h00;
    end else if (!alert_n_i) begin
      run_q <= run_q + 16'h0001;
    end else if (run_q != 16'h0000) begin
      low_cyc_o <= run_q;
      pulses_o  <= pulses_o + 8'h01;
      run_q     <= 16'h0000;
    end
  end
endmodule

// ### sim/pha_alert_gen_asserts.sv
// Concurrent checks on the ports of the alert generator.
`timescale 1ns/1ps
`include "pha_defines.svh"
module pha_alert_asserts (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_en_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_en_i,
  input  wire logic [15:0] reg_rdata_o,
  // Pins.
  input  wire logic        adapter_present_i,
  input  wire logic        comparator_trip_i,
  input  wire logic        processor_hot_alert_n_o
);
  logic [6:0] en_q;
  logic       ext_q;
  logic       clr_q;
  wire        a0 = reg_addr_i == `PHA_ADDR_THR_TIMING;
  wire        a1 = reg_addr_i == `PHA_ADDR_SRC_EN;
  wire        al = processor_hot_alert_n_o;

  // Shadow copies of the enables, the extension bit and clear writes.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q  <= 7'h20;
      ext_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      clr_q <= reg_wr_en_i && a0 && !reg_wdata_i[2];
      if (reg_wr_en_i && a1) en_q <= reg_wdata_i[6:0];
      if (reg_wr_en_i && a0) ext_q <= reg_wdata_i[5];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  rd_unmapped_a: assert property (reg_rd_en_i && !a0 && !a1
    |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  clear_reads_one_a: assert property (
    reg_rd_en_i && a0 |=> reg_rdata_o[2]) else $error("clear bit read 0");
  min_width_a: assert property ($fell(al)
    |-> (!al || en_q == 7'h00)[*8]) else $error("alert pulse short");
  ext_hold_a: assert property ($rose(al) && $past(ext_q, 2)
    && $past(en_q) != 7'h00 |-> clr_q || $past(clr_q))
    else $error("extended alert left without clear");
  all_off_a: assert property ((en_q == 7'h00)[*2] |-> al)
    else $error("alert low with all sources off");
  fell_enabled_a: assert property ($fell(al)
    |-> $past(en_q) != 7'h00) else $error("alert fell while disabled");
  comp_src_a: assert property ((en_q[6] && comparator_trip_i)[*4]
    |-> ##[0:1] !al) else $error("comparator missed");
  adapt_src_a: assert property ((en_q[0] && !adapter_present_i)[*4]
    |-> ##[0:1] !al) else $error("adapter removal missed");

  cover property ($fell(al));
  cover property (ext_q && $rose(al));
  cover property (en_q == 7'h00 && comparator_trip_i);
endmodule

bind pha_alert_gen pha_alert_asserts u_pha_alert_asserts (
  .clock_i, .rst_n_i, .reg_addr_i, .reg_wr_en_i, .reg_wdata_i,
  .reg_rd_en_i, .reg_rdata_o, .adapter_present_i, .comparator_trip_i,
  .processor_hot_alert_n_o);

// ### sim/processor_hot_alert_gen_tb_top.sv
// Self-checking bench for the processor-hot alert generator.
`timescale 1ns/1ps
`include "pha_defines.svh"
module processor_hot_alert_gen_tb_top;
  localparam int unsigned DDEB [4] = '{7, 5, 9, 11};
  localparam int unsigned WID [4]  = '{12, 20, 30, 25};
  localparam logic [15:0] B0       = 16'h4844;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [15:0] wdata   = 16'h0000;
  logic [15:0] in_cur  = 16'h01F4;
  logic [15:0] dis     = 16'h0000;
  logic [15:0] vsys    = 16'h2EE0;
  logic        single  = 1'b0;
  logic        batt    = 1'b1;
  logic        adapt   = 1'b1;
  logic        comp    = 1'b0;
  logic [15:0] rdata;
  logic        alert_n;
  logic [15:0] low_cyc;
  logic [7:0]  pulses;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #25 clock_i = ~clock_i;

  pha_alert_gen #(.CRIT_DEB_CYC('{4, 6, 8, 10}), .VSYS_DEB_CYC(5),
    .NOMINAL_INPUT_OVERCURRENT_DEB_CYC('{6, 12}), .IDCHG_DEB_CYC(DDEB), .WIDTH_CYC(WID))
  u_pha_alert_gen (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_en_i(wr_en), .reg_wdata_i(wdata),
    .reg_rd_en_i(rd_en), .reg_rdata_o(rdata),
    .input_current_ma_i(in_cur), .input_current_limit_ma_i(16'h03E8),
    .discharge_current_ma_i(dis), .system_voltage_mv_i(vsys),
    .single_cell_i(single), .battery_present_i(batt),
    .adapter_present_i(adapt), .comparator_trip_i(comp),
    .processor_hot_alert_n_o(alert_n));

  pha_host_model u_pha_host_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .alert_n_i(alert_n), .low_cyc_o(low_cyc), .pulses_o(pulses));

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    addr = a; wdata = d; wr_en = 1'b1; tick(1);
    wr_en = 1'b0; tick(1);
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] e);
    addr = a; rd_en = 1'b1; tick(1);
    rd_en = 1'b0; tick(1);
    chk_reg("read_data", e, rdata);
  endtask

  task automatic hit(int q, int l);
    tick(q);
    chk_pin("alert_before", 1'b1, alert_n);
    tick(l - q);
    chk_pin("alert_after", 1'b0, alert_n);
  endtask

  task automatic quiet(int n);
    tick(n);
    chk_pin("alert_idle", 1'b1, alert_n);
  endtask

  task automatic s_reset();
    rd(`PHA_ADDR_THR_TIMING, `PHA_RST_THR_TIMING);
    rd(`PHA_ADDR_SRC_EN, `PHA_RST_SRC_EN);
    rd(8'h35, 16'h0000);
  endtask

  task automatic s_crit();
    in_cur = 16'h0668; quiet(20);
    in_cur = 16'h067C; hit(3, 12);
    in_cur = 16'h01F4; quiet(40);
    chk_pin("width_min", 1'b1, low_cyc >= 16'(WID[2]));
    wr(`PHA_ADDR_THR_TIMING, B0);
    in_cur = 16'h067C; hit(2, 8);
    in_cur = 16'h01F4; quiet(30);
    chk_pin("width_sel", 1'b1, low_cyc >= 16'(WID[0])
      && low_cyc <= 16'(WID[0] + 3));
  endtask

  task automatic s_l2();
    int codes [4] = '{1, 25, 26, 30};
    int t;
    foreach (codes[i]) begin
      t = (codes[i] <= 25) ? 105 + 5 * codes[i] : 250 + 50 * (codes[i] - 26);
      t = t * 11;
      wr(`PHA_ADDR_THR_TIMING, (B0 & 16'h07FF) | 16'(codes[i] << 11));
      in_cur = 16'(t - 10); quiet(12);
      in_cur = 16'(t + 10); hit(2, 8);
      in_cur = 16'h01F4; quiet(30);
    end
    wr(`PHA_ADDR_THR_TIMING, B0 | 16'hF800);
    in_cur = 16'hEA60; quiet(20);
    in_cur = 16'h01F4;
  endtask

  task automatic s_ext();
    wr(`PHA_ADDR_THR_TIMING, B0 | 16'h0020);
    in_cur = 16'h067C; hit(2, 8);
    in_cur = 16'h01F4; tick(40);
    chk_pin("alert_extended", 1'b0, alert_n);
    rd(`PHA_ADDR_THR_TIMING, B0 | 16'h0020);
    wr(`PHA_ADDR_THR_TIMING, (B0 | 16'h0020) & 16'hFFFB);
    chk_pin("alert_cleared", 1'b1, alert_n);
    wr(`PHA_ADDR_THR_TIMING, B0);
  endtask

  task automatic s_vsys();
    int t;
    wr(`PHA_ADDR_SRC_EN, 16'h8104);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        single = s[0];
        t = (s == 1 ? 2850 : 5750) + 250 * c;
        wr(`PHA_ADDR_THR_TIMING, (B0 & 16'hFF3F) | 16'(c << 6));
        vsys = 16'(t + 10); quiet(12);
        vsys = 16'(t - 10); hit(2, 8);
        vsys = 16'h2EE0; quiet(30);
      end
    end
    single = 1'b0;
    wr(`PHA_ADDR_THR_TIMING, B0);
  endtask

  task automatic s_idchg();
    for (int d = 0; d < 4; d++) begin
      wr(`PHA_ADDR_SRC_EN, 16'h8008 | 16'(d << 8));
      dis = 16'(32 * 512 + 128 - 10); quiet(14);
      dis = 16'(32 * 512 + 128 + 10);
      hit(DDEB[d] - 3, DDEB[d] + 4);
      dis = 16'h0000; quiet(30);
    end
  endtask

  task automatic s_nominal_input_overcurrent();
    wr(`PHA_ADDR_SRC_EN, 16'h8110);
    in_cur = 16'h0442; quiet(12);
    in_cur = 16'h0456; hit(3, 10);
    in_cur = 16'h01F4; quiet(30);
    wr(`PHA_ADDR_THR_TIMING, B0 | 16'h0002);
    in_cur = 16'h0456; hit(9, 16);
    in_cur = 16'h01F4; quiet(30);
    wr(`PHA_ADDR_THR_TIMING, B0);
  endtask

  task automatic s_pins();
    logic [7:0] p;
    wr(`PHA_ADDR_SRC_EN, 16'h8140);
    comp = 1'b1; hit(1, 6);
    comp = 1'b0; quiet(30);
    wr(`PHA_ADDR_SRC_EN, 16'h8000);
    comp = 1'b1; quiet(20);
    comp = 1'b0;
    wr(`PHA_ADDR_SRC_EN, 16'h8101);
    adapt = 1'b0; hit(1, 6);
    adapt = 1'b1; quiet(30);
    wr(`PHA_ADDR_SRC_EN, 16'h8102);
    p = pulses;
    batt = 1'b0; hit(1, 7);
    quiet(30);
    chk_reg("pulse_count", {8'h00, p + 8'h01}, {8'h00, pulses});
    batt = 1'b1; quiet(10);
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    tick(3);
    rst_n_i = 1'b1;
    tick(1);
    s_reset();
    s_crit();
    s_l2();
    s_ext();
    s_vsys();
    s_idchg();
    s_nominal_input_overcurrent();
    s_pins();
    print_verdict();
  end
endmodule
